// ---- dual_timer.sv ----
// Module: two 8-bit timer/event counters with cascade, PWM and interrupts
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Counter A clock: main, /2,/8,/32,/128,/4096
// - Counter B clock: main, /2,/8,/32,/256,/512
// - Interval mode interrupts once per interval
// - Event mode counts valid input edges
// - Square wave toggles output each interval
// - Each counter can drive 8-bit PWM
// - Cascade makes one 16-bit timer/counter
// - Cascade square wave, 16-bit half period
// - Compare equality raises own match interrupt
// - Compare registers hold any byte value
// - Reset clears both compare registers
// - Two counters, compares and outputs
// - Non-PWM match clears counter and restarts
// - Run control cleared stops, forces zero
module dual_timer (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  input  wire logic        event_in_a,
  input  wire logic        event_in_b,
  output logic             wave_out_a,
  output logic             wave_out_b,
  output logic             match_irq_a,
  output logic             match_irq_b,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Register file state
  // ----------------------------------------------------------------
  logic [7:0] compare_value_r [tmr_pkg::NUM_CNT];   // Compare values
  logic [7:0] compare_value_nxt [tmr_pkg::NUM_CNT];
  logic [2:0] count_clock_select_r [tmr_pkg::NUM_CNT]; // Clock selects
  logic [2:0] count_clock_select_nxt [tmr_pkg::NUM_CNT];
  logic [7:0] mode_control_r [tmr_pkg::NUM_CNT];    // Mode controls
  logic [7:0] mode_control_nxt [tmr_pkg::NUM_CNT];
  logic [1:0] irqStat_r, irqStat_nxt;               // Sticky status
  logic [1:0] irqEn_r, irqEn_nxt;                   // Enable mask
  logic [7:0] rdata_r, rdata_nxt;                   // Read data

  // ----------------------------------------------------------------
  // Counting state
  // ----------------------------------------------------------------
  logic [7:0] counter_r [tmr_pkg::NUM_CNT];         // Counters A and B
  logic [7:0] counter_nxt [tmr_pkg::NUM_CNT];
  logic [1:0] match_r, match_nxt;                   // Match pulses
  logic [tmr_pkg::PRESCALE_W-1:0] prescale_r, prescale_nxt; // Free divider
  logic [1:0] tick;                                 // Selected count ticks
  logic [1:0] wave;                                 // Output stage levels
  logic [1:0] setStb, rstStb;                       // Output set/reset strobes
  logic       cascade;                              // Cascade enabled
  logic [1:0] run, pwm;                             // Mode bits per counter

  // Write decode helper
  function automatic logic wr_hit(input logic w, input logic [3:0] a, input logic [3:0] t);
    wr_hit = w && (a == t);
  endfunction : wr_hit

  assign cascade = mode_control_r[1][tmr_pkg::MODE_CASC];

  // ----------------------------------------------------------------
  // Clock selection and output stages per counter
  // ----------------------------------------------------------------
  tmr_tick_sel #(
    .S3 (tmr_pkg::A_SHIFT3),
    .S4 (tmr_pkg::A_SHIFT4),
    .S5 (tmr_pkg::A_SHIFT5),
    .S6 (tmr_pkg::A_SHIFT6),
    .S7 (tmr_pkg::A_SHIFT7)
  ) u_tick_a (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .prescale (prescale_r),
    .clkSel   (count_clock_select_r[0]),
    .eventIn  (event_in_a),
    .tick     (tick[0])
  );

  tmr_tick_sel #(
    .S3 (tmr_pkg::B_SHIFT3),
    .S4 (tmr_pkg::B_SHIFT4),
    .S5 (tmr_pkg::B_SHIFT5),
    .S6 (tmr_pkg::B_SHIFT6),
    .S7 (tmr_pkg::B_SHIFT7)
  ) u_tick_b (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .prescale (prescale_r),
    .clkSel   (count_clock_select_r[1]),
    .eventIn  (event_in_b),
    .tick     (tick[1])
  );

  genvar gi;
  generate
    for (gi = 0; gi < tmr_pkg::NUM_CNT; gi++)
    begin : g_out
      assign run[gi]    = mode_control_r[gi][tmr_pkg::MODE_RUN];
      assign pwm[gi]    = mode_control_r[gi][tmr_pkg::MODE_PWM] & ~cascade;
      assign setStb[gi] = wr_hit(regWr, regAddr, tmr_pkg::ADDR_MODE_A + 4'(gi)) & regWdata[tmr_pkg::MODE_SET];
      assign rstStb[gi] = wr_hit(regWr, regAddr, tmr_pkg::ADDR_MODE_A + 4'(gi)) & regWdata[tmr_pkg::MODE_RST];
      // Cascade drives the A output from the 16-bit match
      tmr_wave_out u_wave (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .pwmMode   (pwm[gi]),
        .invEn     (mode_control_r[gi][tmr_pkg::MODE_INV]),
        .outEn     (mode_control_r[gi][tmr_pkg::MODE_OE]),
        .setStb    (setStb[gi]),
        .rstStb    (rstStb[gi]),
        .toggle    (match_r[gi]),
        .pwmActive (run[gi] && (counter_r[gi] < compare_value_r[gi])),
        .wave      (wave[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Counter next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic eqA, eqB, eq16, advB;
    eqA  = (counter_r[0] == compare_value_r[0]);
    eqB  = (counter_r[1] == compare_value_r[1]);
    eq16 = eqA && eqB;
    advB = tick[0] && (counter_r[0] == 8'hff);
    prescale_nxt = prescale_r + 1'b1;
    counter_nxt  = counter_r;
    match_nxt    = 2'b00;
    if (cascade)
    begin
      // 16-bit pair: A low byte, B high byte
      if (!run[0])
      begin
        counter_nxt[0] = tmr_pkg::BYTE_ZERO;
        counter_nxt[1] = tmr_pkg::BYTE_ZERO;
      end
      else if (tick[0] && eq16)
      begin
        counter_nxt[0] = tmr_pkg::BYTE_ZERO;
        counter_nxt[1] = tmr_pkg::BYTE_ZERO;
        match_nxt[0]   = 1'b1;
      end
      else if (tick[0])
      begin
        counter_nxt[0] = counter_r[0] + 8'h01;
        if (advB)
          counter_nxt[1] = counter_r[1] + 8'h01;
      end
    end
    else
    begin
      for (int i = 0; i < tmr_pkg::NUM_CNT; i++)
      begin
        if (!run[i])
          counter_nxt[i] = tmr_pkg::BYTE_ZERO;
        else if (tick[i])
        begin
          if (counter_r[i] == compare_value_r[i])
          begin
            match_nxt[i] = 1'b1;
            // Clear and restart unless free-running PWM
            counter_nxt[i] = pwm[i] ? counter_r[i] + 8'h01 : tmr_pkg::BYTE_ZERO;
          end
          else
            counter_nxt[i] = counter_r[i] + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file next state and read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    compare_value_nxt      = compare_value_r;
    count_clock_select_nxt = count_clock_select_r;
    mode_control_nxt       = mode_control_r;
    irqEn_nxt              = irqEn_r;
    // Hardware set wins over software clear
    irqStat_nxt = irqStat_r;
    if (wr_hit(regWr, regAddr, tmr_pkg::ADDR_IRQ_CLR))
      irqStat_nxt = irqStat_r & ~regWdata[1:0];
    irqStat_nxt = irqStat_nxt | match_r;
    for (int i = 0; i < tmr_pkg::NUM_CNT; i++)
    begin
      if (wr_hit(regWr, regAddr, tmr_pkg::ADDR_CMP_A + 4'(i)))
        compare_value_nxt[i] = regWdata;
      if (wr_hit(regWr, regAddr, tmr_pkg::ADDR_CLK_A + 4'(i)))
        count_clock_select_nxt[i] = regWdata[2:0];
      if (wr_hit(regWr, regAddr, tmr_pkg::ADDR_MODE_A + 4'(i)))
      begin
        // Set/reset strobes are not stored
        mode_control_nxt[i] = regWdata;
        mode_control_nxt[i][tmr_pkg::MODE_SET] = 1'b0;
        mode_control_nxt[i][tmr_pkg::MODE_RST] = 1'b0;
        if (i == 0)
          mode_control_nxt[i][tmr_pkg::MODE_CASC] = 1'b0;
      end
    end
    if (wr_hit(regWr, regAddr, tmr_pkg::ADDR_IRQ_EN))
      irqEn_nxt = regWdata[1:0];
    // Read data for the following cycle
    rdata_nxt = tmr_pkg::BYTE_ZERO;
    if (regRd)
    begin
      case (regAddr)
        tmr_pkg::ADDR_CMP_A:  rdata_nxt = compare_value_r[0];
        tmr_pkg::ADDR_CMP_B:  rdata_nxt = compare_value_r[1];
        tmr_pkg::ADDR_CNT_A:  rdata_nxt = counter_r[0];
        tmr_pkg::ADDR_CNT_B:  rdata_nxt = counter_r[1];
        tmr_pkg::ADDR_CLK_A:  rdata_nxt = {5'h00, count_clock_select_r[0]};
        tmr_pkg::ADDR_CLK_B:  rdata_nxt = {5'h00, count_clock_select_r[1]};
        tmr_pkg::ADDR_MODE_A: rdata_nxt = mode_control_r[0];
        tmr_pkg::ADDR_MODE_B: rdata_nxt = mode_control_r[1];
        tmr_pkg::ADDR_IRQ_ST: rdata_nxt = {6'h00, irqStat_r};
        tmr_pkg::ADDR_IRQ_EN: rdata_nxt = {6'h00, irqEn_r};
        default:              rdata_nxt = tmr_pkg::BYTE_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register stage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < tmr_pkg::NUM_CNT; i++)
      begin
        compare_value_r[i]      <= tmr_pkg::CMP_RESET;
        count_clock_select_r[i] <= tmr_pkg::CS_EXT_FALL;
        mode_control_r[i]       <= tmr_pkg::BYTE_ZERO;
        counter_r[i]            <= tmr_pkg::BYTE_ZERO;
      end
      irqStat_r  <= 2'b00;
      irqEn_r    <= 2'b00;
      rdata_r    <= tmr_pkg::BYTE_ZERO;
      match_r    <= 2'b00;
      prescale_r <= '0;
    end
    else
    begin
      compare_value_r      <= compare_value_nxt;
      count_clock_select_r <= count_clock_select_nxt;
      mode_control_r       <= mode_control_nxt;
      counter_r            <= counter_nxt;
      irqStat_r            <= irqStat_nxt;
      irqEn_r              <= irqEn_nxt;
      rdata_r              <= rdata_nxt;
      match_r              <= match_nxt;
      prescale_r           <= prescale_nxt;
    end
  end

  // Interrupt level register
  logic irq_r, irq_nxt;
  assign irq_nxt = |(irqStat_nxt & irqEn_nxt);
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irq_r <= 1'b0;
    else
      irq_r <= irq_nxt;
  end

  // Outputs straight from flip-flops
  assign regRdata    = rdata_r;
  assign match_irq_a = match_r[0];
  assign match_irq_b = match_r[1];
  assign irq         = irq_r;
  assign wave_out_a  = wave[0];
  assign wave_out_b  = wave[1];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_match_a;
    run[0] && !cascade && !pwm[0] && tick[0] && (counter_r[0] == compare_value_r[0]);
  endsequence

  AST_MATCH_CLEARS: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_match_a |=> (counter_r[0] == 8'h00) && match_irq_a)
    else $error("counter A not cleared on match");

  AST_STOP_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
    !run[1] && !cascade |=> counter_r[1] == 8'h00)
    else $error("stopped counter B not zero");

  AST_IRQ_STICKY: assert property (@(posedge ref_clk) disable iff (!rstn)
    match_irq_b |=> irqStat_r[1])
    else $error("match B did not set status");

  AST_MATCH_EQ: assert property (@(posedge ref_clk) disable iff (!rstn)
    match_irq_b |-> $past(counter_r[1] == compare_value_r[1]))
    else $error("match B without equality");

  AST_CMP_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
    regWr && regAddr == tmr_pkg::ADDR_CMP_A |=> compare_value_r[0] == $past(regWdata))
    else $error("compare A write lost");

  AST_CASC_CARRY: assert property (@(posedge ref_clk) disable iff (!rstn)
    cascade && run[0] && tick[0] && counter_r[0] == 8'hff && !(counter_r[0] == compare_value_r[0]
      && counter_r[1] == compare_value_r[1]) |=> counter_r[1] == $past(counter_r[1]) + 8'h01)
    else $error("cascade carry missed");

  AST_MAIN_CLK: assert property (@(posedge ref_clk) disable iff (!rstn)
    run[0] && !cascade && count_clock_select_r[0] == tmr_pkg::CS_DIV1
      && counter_r[0] != compare_value_r[0] |=> counter_r[0] == $past(counter_r[0]) + 8'h01)
    else $error("counter A did not advance on main clock");

  AST_IRQ_OUT: assert property (@(posedge ref_clk) disable iff (!rstn)
    irq == |(irqStat_r & irqEn_r))
    else $error("interrupt output mismatch");

  AST_PWM_LOW: assert property (@(posedge ref_clk) disable iff (!rstn)
    pwm[0] && mode_control_r[0][tmr_pkg::MODE_OE] && !mode_control_r[0][tmr_pkg::MODE_INV] && !run[0]
      ##1 $stable(mode_control_r[0]) |=> !wave_out_a)
    else $error("PWM output active while stopped");

endmodule : dual_timer
`default_nettype wire

// ---- tmr_pkg.sv ----
// Package: register map, field layout and constants for the dual 8-bit timer
package tmr_pkg;

  // ----------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CMP_A   = 4'h0;  // Compare value A
  localparam logic [3:0] ADDR_CMP_B   = 4'h1;  // Compare value B
  localparam logic [3:0] ADDR_CNT_A   = 4'h2;  // Counter A (read only)
  localparam logic [3:0] ADDR_CNT_B   = 4'h3;  // Counter B (read only)
  localparam logic [3:0] ADDR_CLK_A   = 4'h4;  // Count clock select A
  localparam logic [3:0] ADDR_CLK_B   = 4'h5;  // Count clock select B
  localparam logic [3:0] ADDR_MODE_A  = 4'h6;  // Mode control A
  localparam logic [3:0] ADDR_MODE_B  = 4'h7;  // Mode control B
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h8;  // Interrupt status (read only)
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h9;  // Interrupt enable
  localparam logic [3:0] ADDR_IRQ_CLR = 4'ha;  // Interrupt clear (write only)

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMP_RESET  = 8'h00;   // Compare registers
  localparam logic [7:0] BYTE_ZERO  = 8'h00;   // Generic zero byte

  // ----------------------------------------------------------------
  // Mode control field positions
  // ----------------------------------------------------------------
  localparam int MODE_RUN    = 7;  // Run enable, clear forces counter zero
  localparam int MODE_PWM    = 6;  // 1 = PWM, 0 = clear on match
  localparam int MODE_CASC   = 5;  // Cascade (B register only)
  localparam int MODE_SET    = 3;  // Output set strobe
  localparam int MODE_RST    = 2;  // Output reset strobe
  localparam int MODE_INV    = 1;  // Toggle enable / PWM active low
  localparam int MODE_OE     = 0;  // Output enable

  // ----------------------------------------------------------------
  // Count clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_EXT_FALL = 3'h0;   // Event input falling
  localparam logic [2:0] CS_EXT_RISE = 3'h1;   // Event input rising
  localparam logic [2:0] CS_DIV1     = 3'h2;   // Main clock

  // Divider exponents for codes 3..7
  localparam int A_SHIFT3 = 1;
  localparam int A_SHIFT4 = 3;
  localparam int A_SHIFT5 = 5;
  localparam int A_SHIFT6 = 7;
  localparam int A_SHIFT7 = 12;
  localparam int B_SHIFT3 = 1;
  localparam int B_SHIFT4 = 3;
  localparam int B_SHIFT5 = 5;
  localparam int B_SHIFT6 = 8;
  localparam int B_SHIFT7 = 9;

  localparam int PRESCALE_W = 12;  // Free prescaler width
  localparam int NUM_CNT    = 2;   // Two counters

endpackage : tmr_pkg

// ---- tmr_tick_sel.sv ----
// Module: count clock selector producing one-cycle count ticks
`timescale 1ns/1ps
`default_nettype none
module tmr_tick_sel #(
  parameter int S3 = 1,
  parameter int S4 = 3,
  parameter int S5 = 5,
  parameter int S6 = 7,
  parameter int S7 = 12
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rstn,
  input  wire logic [tmr_pkg::PRESCALE_W-1:0]  prescale,
  input  wire logic [2:0]                      clkSel,
  input  wire logic                            eventIn,
  output logic                                 tick
);

  // ----------------------------------------------------------------
  // Pin synchroniser and edge history
  // ----------------------------------------------------------------
  logic syncA_r, syncB_r, prev_r;      // Two stages and last value
  logic syncA_nxt, syncB_nxt, prev_nxt;

  // Prescaler bit that falls from 1 to 0 once per period
  function automatic logic div_edge(input logic [tmr_pkg::PRESCALE_W-1:0] p, input int s);
    logic [tmr_pkg::PRESCALE_W-1:0] mask;  // Low s bits set, fixed-range select
    mask     = '1;
    mask     = mask >> (tmr_pkg::PRESCALE_W - s);
    div_edge = ((p & mask) == '0);
  endfunction : div_edge

  // Next values and tick decode
  always_comb
  begin
    syncA_nxt = eventIn;
    syncB_nxt = syncA_r;
    prev_nxt  = syncB_r;
    case (clkSel)
      tmr_pkg::CS_EXT_FALL: tick = prev_r & ~syncB_r;
      tmr_pkg::CS_EXT_RISE: tick = ~prev_r & syncB_r;
      tmr_pkg::CS_DIV1:     tick = 1'b1;
      3'h3:                 tick = div_edge(prescale, S3);
      3'h4:                 tick = div_edge(prescale, S4);
      3'h5:                 tick = div_edge(prescale, S5);
      3'h6:                 tick = div_edge(prescale, S6);
      default:              tick = div_edge(prescale, S7);
    endcase
  end

  // Register stage
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      syncA_r <= syncA_nxt;
      syncB_r <= syncB_nxt;
      prev_r  <= prev_nxt;
    end
  end

endmodule : tmr_tick_sel
`default_nettype wire

// ---- tmr_wave_out.sv ----
// Module: output flip-flop for toggle, set/reset and PWM waveforms
`timescale 1ns/1ps
`default_nettype none
module tmr_wave_out (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic pwmMode,
  input  wire logic invEn,
  input  wire logic outEn,
  input  wire logic setStb,
  input  wire logic rstStb,
  input  wire logic toggle,
  input  wire logic pwmActive,
  output logic      wave
);

  logic ff_r, ff_nxt;       // Square-wave flip-flop
  logic wave_r, wave_nxt;   // Registered pin level

  // Next state of output flip-flop and pin
  always_comb
  begin
    ff_nxt = ff_r;
    if (setStb)
      ff_nxt = 1'b1;
    else if (rstStb)
      ff_nxt = 1'b0;
    else if (toggle && invEn)
      ff_nxt = ~ff_r;
    if (!outEn)
      wave_nxt = 1'b0;
    else if (pwmMode)
      wave_nxt = pwmActive ^ invEn;
    else
      wave_nxt = ff_r;
  end

  // Register stage
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ff_r   <= 1'b0;
      wave_r <= 1'b0;
    end
    else
    begin
      ff_r   <= ff_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign wave = wave_r;

endmodule : tmr_wave_out
`default_nettype wire

// ---- ev_pin_model.sv ----
// Partner model: drives the two external count pins of the timer
`timescale 1ns/1ps
`default_nettype none
module ev_pin_model (
  input  wire logic ref_clk,
  output logic      evA,
  output logic      evB
);
  // ----------------------------------------
  // Pin driver
  // ----------------------------------------
  // Pins idle low until a burst is asked for
  initial
  begin
    evA = 1'b0;
    evB = 1'b0;
  end

  // Burst of pulses, each level held long enough to pass the synchroniser
  task automatic pulses(input bit pinB, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      if (pinB)
        evB <= 1'b1;
      else
        evA <= 1'b1;
      repeat (4) @(posedge ref_clk);
      evA <= 1'b0;
      evB <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask : pulses
endmodule : ev_pin_model
`default_nettype wire

// ---- tb.sv ----
// Testbench: register, interval, event, square-wave, PWM and cascade checks
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        ref_clk;     // 40 MHz clock
  logic        rstn;        // Async reset, active low
  logic [3:0]  regAddr;     // Register index
  logic [7:0]  regWdata;    // Write data
  logic        regWr;       // Write strobe
  logic        regRd;       // Read strobe
  logic [7:0]  regRdata;    // Read data
  logic        evA;         // Event pin A
  logic        evB;         // Event pin B
  logic        waveA;       // Timer output A
  logic        waveB;       // Timer output B
  logic        irqA;        // Match pulse A
  logic        irqB;        // Match pulse B
  logic        irq;         // Combined interrupt
  int          fail_count;  // Mismatches
  int          cmp_count;   // Comparisons
  logic [7:0]  rdv;         // Last read value
  logic [15:0] gap;         // Measured spacing
  int          hi;          // High cycles of PWM
  int          divTab[6] = '{1, 2, 8, 32, 128, 4096};  // Divisors A
  int          divTbB[6] = '{1, 2, 8, 32, 256, 512};   // Divisors B

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  dual_timer DUT (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .event_in_a(evA), .event_in_b(evB), .wave_out_a(waveA),
    .wave_out_b(waveB), .match_irq_a(irqA), .match_irq_b(irqB), .irq(irq));
  ev_pin_model PEER (.ref_clk(ref_clk), .evA(evA), .evB(evB));

  // Clock, 25 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // One-cycle byte write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  // One-cycle read, data sampled in the following cycle
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    rdv = regRdata;
  endtask : rd

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Event seen: match pulse A, match pulse B, or change of output A
  function automatic bit hit(input int s, input logic p);
    return (s == 0) ? (irqA === 1'b1) : (s == 1) ? (irqB === 1'b1) : (waveA !== p);
  endfunction : hit

  // Cycles between two consecutive events
  task automatic gapOf(input int s, output logic [15:0] g);
    logic p;
    int   n;
    p = waveA;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (!hit(s, p) && n < 10000);
    p = waveA;
    g = 16'h0000;
    do begin @(negedge ref_clk); g++; end while (!hit(s, p) && g < 16'h2710);
  endtask : gapOf

  // Verdict and end of run
  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rstn, regAddr, regWdata, regWr, regRd} = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(tmr_pkg::ADDR_CMP_A); chk(rdv, 16'h0000);
    rd(tmr_pkg::ADDR_CMP_B); chk(rdv, 16'h0000);
    foreach (divTab[i])
    begin
      wr(tmr_pkg::ADDR_CMP_A, 8'h33 * i);
      wr(tmr_pkg::ADDR_CMP_B, 8'hff - 8'h33 * i);
      rd(tmr_pkg::ADDR_CMP_A); chk(rdv, 8'h33 * i);
      rd(tmr_pkg::ADDR_CMP_B); chk(rdv, 8'hff - 8'h33 * i);
    end
    wr(tmr_pkg::ADDR_CNT_A, 8'h5a);
    rd(tmr_pkg::ADDR_CNT_A); chk(rdv, 16'h0000);
    rd(4'hf); chk(rdv, 16'h0000);
    // Interval timer with masked interrupt, stop, then unmask and clear
    wr(tmr_pkg::ADDR_CMP_A, 8'h02);
    wr(tmr_pkg::ADDR_CLK_A, 8'h02);
    wr(tmr_pkg::ADDR_MODE_A, 8'h80);
    gapOf(0, gap); chk(gap, 16'd3);
    chk(irq, 1'b0);
    wr(tmr_pkg::ADDR_MODE_A, 8'h00);
    rd(tmr_pkg::ADDR_CNT_A); chk(rdv, 16'h0000);
    rd(tmr_pkg::ADDR_IRQ_ST); chk(rdv, 16'h0001);
    wr(tmr_pkg::ADDR_IRQ_EN, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk(irq, 1'b1);
    wr(tmr_pkg::ADDR_IRQ_CLR, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk(irq, 1'b0);
    rd(tmr_pkg::ADDR_IRQ_ST); chk(rdv, 16'h0000);
    // Every internal count clock on both counters, shortest interval
    for (int c = 2; c < 8; c++)
    begin
      wr(tmr_pkg::ADDR_MODE_A, 8'h00);
      wr(tmr_pkg::ADDR_MODE_B, 8'h00);
      wr(tmr_pkg::ADDR_CLK_A, c[7:0]);
      wr(tmr_pkg::ADDR_CLK_B, c[7:0]);
      wr(tmr_pkg::ADDR_CMP_A, 8'h00);
      wr(tmr_pkg::ADDR_CMP_B, 8'h00);
      wr(tmr_pkg::ADDR_MODE_A, 8'h80);
      wr(tmr_pkg::ADDR_MODE_B, 8'h80);
      gapOf(0, gap); chk(gap, divTab[c-2]);
      gapOf(1, gap); chk(gap, divTbB[c-2]);
    end
    // Square wave on output A
    wr(tmr_pkg::ADDR_MODE_A, 8'h00);
    wr(tmr_pkg::ADDR_MODE_B, 8'h00);
    wr(tmr_pkg::ADDR_CLK_A, 8'h02);
    wr(tmr_pkg::ADDR_CMP_A, 8'h05);
    wr(tmr_pkg::ADDR_MODE_A, 8'h83);
    gapOf(2, gap); chk(gap, 16'd6);
    // Event counting, rising edges on A and falling edges on B
    wr(tmr_pkg::ADDR_MODE_A, 8'h00);
    wr(tmr_pkg::ADDR_CLK_A, 8'h01);
    wr(tmr_pkg::ADDR_CLK_B, 8'h00);
    wr(tmr_pkg::ADDR_CMP_A, 8'hff);
    wr(tmr_pkg::ADDR_CMP_B, 8'hff);
    wr(tmr_pkg::ADDR_MODE_A, 8'h80);
    wr(tmr_pkg::ADDR_MODE_B, 8'h80);
    PEER.pulses(1'b0, 5);
    PEER.pulses(1'b1, 3);
    repeat (8) @(negedge ref_clk);
    rd(tmr_pkg::ADDR_CNT_A); chk(rdv, 16'd5);
    rd(tmr_pkg::ADDR_CNT_B); chk(rdv, 16'd3);
    // PWM on the main clock, compare set before the mode
    wr(tmr_pkg::ADDR_MODE_A, 8'h00);
    wr(tmr_pkg::ADDR_MODE_B, 8'h00);
    wr(tmr_pkg::ADDR_CLK_A, 8'h02);
    wr(tmr_pkg::ADDR_CMP_A, 8'h40);
    wr(tmr_pkg::ADDR_MODE_A, 8'hc1);
    hi = 0;
    repeat (256) @(negedge ref_clk) hi += waveA;
    chk(hi[15:0], 16'd64);
    // PWM on counter B, active low, window starts at its first driven level
    wr(tmr_pkg::ADDR_CLK_B, 8'h02);
    wr(tmr_pkg::ADDR_CMP_B, 8'hc0);
    wr(tmr_pkg::ADDR_MODE_B, 8'hc3);
    hi = 0;
    @(negedge ref_clk);
    repeat (256) @(negedge ref_clk) hi += waveB;
    chk(hi[15:0], 16'd64);
    // Stopped PWM holds output inactive, then output set and reset strobes
    wr(tmr_pkg::ADDR_MODE_A, 8'h41);
    repeat (2) @(negedge ref_clk);
    chk(waveA, 1'b0);
    wr(tmr_pkg::ADDR_MODE_A, 8'h09);
    repeat (2) @(negedge ref_clk);
    chk(waveA, 1'b1);
    wr(tmr_pkg::ADDR_MODE_A, 8'h05);
    rd(tmr_pkg::ADDR_MODE_A); chk(rdv, 16'h0001);
    chk(waveA, 1'b0);
    // Cascade, 16-bit compare 0101
    wr(tmr_pkg::ADDR_MODE_A, 8'h00);
    wr(tmr_pkg::ADDR_CMP_A, 8'h01);
    wr(tmr_pkg::ADDR_CMP_B, 8'h01);
    wr(tmr_pkg::ADDR_MODE_B, 8'h20);
    wr(tmr_pkg::ADDR_MODE_A, 8'h83);
    gapOf(0, gap); chk(gap, 16'd258);
    gapOf(2, gap); chk(gap, 16'd258);
    complete_run();
  end
endmodule : tb
`default_nettype wire
